// ### hw/fsp_pkg.sv
// fsp_pkg: shared constants and carrier types for the flash self-program section control.
// assumes a word-addressed program flash of fixed size, page-granular programming.
package fsp_pkg;
  localparam int unsigned ADDR_W = 15;
  localparam int unsigned SIZE_W = 2;
  localparam logic [14:0] STALL_AREA_START = 15'h7000;
  localparam logic [14:0] LOADER_START_SZ0 = 15'h7000;
  localparam logic [14:0] LOADER_START_SZ1 = 15'h7800;
  localparam logic [14:0] LOADER_START_SZ2 = 15'h7c00;
  localparam logic [14:0] LOADER_START_SZ3 = 15'h7e00;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned PROG_TIME_US = 4;
  localparam int unsigned PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
  localparam logic [15:0] PROG_CYCLES_W = 16'(PROG_CYCLES);
  localparam int unsigned AXI_AW = 4;
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam int unsigned CTRL_BUSY_CLR_BIT = 0;
  localparam int unsigned ST_BUSY_BIT = 0;
  localparam int unsigned ST_ACTIVE_BIT = 1;
  localparam int unsigned ST_HALT_BIT = 2;
  localparam int unsigned ST_REFUSED_BIT = 3;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    FSP_OP_NONE,
    FSP_OP_ERASE,
    FSP_OP_WRITE
  } fsp_op_t;

  typedef struct packed {
    logic valid;
    fsp_op_t op;
    logic [14:0] pc;
    logic [14:0] target;
  } fsp_req_t;

  typedef struct packed {
    logic [1:0] app_lock;
    logic [1:0] loader_lock;
    logic [1:0] loader_size;
  } fsp_fuse_t;
endpackage

// ### hw/fsp_area_map.sv
// fsp_area_map: combinational decode of one flash word address into its areas.
// assumes fuses are stable while the device runs.
`timescale 1ns/1ns
`default_nettype none
module fsp_area_map (
  input wire logic [14:0] i_addr,
  input wire logic [1:0] i_loader_size,
  output logic o_in_loader,
  output logic o_in_stall
);
  logic [14:0] loader_start;

  always_comb begin
    unique case (i_loader_size)
      2'h0: loader_start = fsp_pkg::LOADER_START_SZ0;
      2'h1: loader_start = fsp_pkg::LOADER_START_SZ1;
      2'h2: loader_start = fsp_pkg::LOADER_START_SZ2;
      2'h3: loader_start = fsp_pkg::LOADER_START_SZ3;
    endcase
  end

  assign o_in_loader = (i_addr >= loader_start);
  // every loader start lies at or above the stall boundary
  assign o_in_stall = (i_addr >= fsp_pkg::STALL_AREA_START);
endmodule // fsp_area_map
`default_nettype wire

// ### hw/fsp_ctrl.sv
// fsp_ctrl: gates store-program requests by executing area and lock bits,
// runs the page operation timer, stalls the cpu and holds the busy flag.
// assumes the cpu presents one request pulse per store-program instruction.
//
// The register offsets and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - program only when executing from loader area
// - loader code may target any address
// - loader boundary comes from size fuses
// - two independent lock sets, one per area
// - fixed concurrent/stall boundary, fuse independent
// - concurrent-area operation keeps cpu running
// - stall-area operation halts cpu throughout
// - loader area always inside stall area
// - busy flag reads one while blocked
// - busy stays until software clears it
module fsp_ctrl (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire fsp_pkg::fsp_req_t i_req,
  input wire fsp_pkg::fsp_fuse_t i_fuse,
  output logic o_cpu_halt,
  output logic o_area_blocked,
  output logic o_flash_start,
  output fsp_pkg::fsp_op_t o_flash_op,
  output logic [14:0] o_flash_addr,
  input wire logic [3:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [3:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready
);
  typedef enum logic [1:0] {
    FSP_IDLE,
    FSP_RUN_CONC,
    FSP_RUN_STALL
  } fsp_state_t;

  fsp_state_t state_reg;
  logic [15:0] count_reg;
  logic busy_reg;
  logic refused_reg;
  logic pc_in_loader;
  logic prog_active;
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic [31:0] status_now;
  logic tgt_in_loader;
  logic tgt_in_stall;
  logic lock_ok;
  logic accept;
  logic refuse;
  logic done;
  logic [3:0] aw_addr_reg;
  logic aw_have_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic w_have_reg;
  logic wr_fire;
  logic wr_hit;
  logic busy_clr;

  // lock bits read low when programmed; a low bit0 forbids self-programming of that area
  function automatic logic lock_allows(input logic [1:0] lock);
    lock_allows = lock[0];
  endfunction

  // the none code is an ordinary instruction and neither starts nor is refused
  function automatic logic is_prog_op(input fsp_pkg::fsp_op_t op);
    is_prog_op = (op != fsp_pkg::FSP_OP_NONE);
  endfunction

  // both bus channels share one small register map
  function automatic logic is_known_addr(input logic [3:0] addr);
    is_known_addr = (addr == fsp_pkg::OFS_CTRL) || (addr == fsp_pkg::OFS_STATUS);
  endfunction

  // status layout assembled in one place
  function automatic logic [31:0] status_word(input logic busy, input logic active,
                                              input logic halt, input logic refused);
    status_word = 32'h0000_0000;
    status_word[fsp_pkg::ST_BUSY_BIT] = busy;
    status_word[fsp_pkg::ST_ACTIVE_BIT] = active;
    status_word[fsp_pkg::ST_HALT_BIT] = halt;
    status_word[fsp_pkg::ST_REFUSED_BIT] = refused;
  endfunction

  fsp_area_map u_pc_map (
    .i_addr(i_req.pc),
    .i_loader_size(i_fuse.loader_size),
    .o_in_loader(pc_in_loader),
    .o_in_stall()
  );

  fsp_area_map u_tgt_map (
    .i_addr(i_req.target),
    .i_loader_size(i_fuse.loader_size),
    .o_in_loader(tgt_in_loader),
    .o_in_stall(tgt_in_stall)
  );

  // each target area checks only its own lock set
  assign lock_ok = tgt_in_loader ? lock_allows(i_fuse.loader_lock)
                                 : lock_allows(i_fuse.app_lock);
  // no address limit on the target once issued from the loader area
  assign accept = i_req.valid && is_prog_op(i_req.op) && pc_in_loader
                  && lock_ok && (state_reg == FSP_IDLE);
  assign refuse = i_req.valid && is_prog_op(i_req.op) && !accept;
  assign prog_active = (state_reg != FSP_IDLE);
  // ending on the last count keeps the active time exactly one page time
  assign done = prog_active && (count_reg == 16'h0001);

  // a request that arrives while an operation runs is refused, never queued
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= FSP_IDLE;
    end else if (accept) begin
      state_reg <= tgt_in_stall ? FSP_RUN_STALL : FSP_RUN_CONC;
    end else if (done) begin
      state_reg <= FSP_IDLE;
    end
  end

  // fixed cycle count: another system clock rate needs another CLK_MHZ
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      count_reg <= 16'h0000;
    end else if (accept) begin
      count_reg <= fsp_pkg::PROG_CYCLES_W;
    end else if (state_reg != FSP_IDLE) begin
      count_reg <= count_reg - 16'h0001;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_flash_start <= 1'b0;
    end else begin
      o_flash_start <= accept;
    end
  end

  // operation and address stay latched for the array after the start pulse
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_flash_op <= fsp_pkg::FSP_OP_NONE;
    end else if (accept) begin
      o_flash_op <= i_req.op;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_flash_addr <= 15'h0000;
    end else if (accept) begin
      o_flash_addr <= i_req.target;
    end
  end

  // set beats clear; the flag outlives the operation until software clears it
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      busy_reg <= 1'b0;
    end else if (accept && !tgt_in_stall) begin
      busy_reg <= 1'b1;
    end else if (busy_clr && state_reg != FSP_RUN_CONC) begin
      busy_reg <= 1'b0;
    end
  end

  // refused is only a hint for software; it never blocks a later request
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      refused_reg <= 1'b0;
    end else if (accept) begin
      refused_reg <= 1'b0;
    end else if (refuse) begin
      refused_reg <= 1'b1;
    end
  end

  assign o_cpu_halt = (state_reg == FSP_RUN_STALL);
  // software must keep out of the blocked area while this is high
  assign o_area_blocked = busy_reg;

  // axi4-lite write: address and data taken in either order
  // both channels stall while a response waits, so no write is lost behind it
  assign o_awready = !aw_have_reg && !o_bvalid;
  assign o_wready = !w_have_reg && !o_bvalid;
  assign aw_take = i_awvalid && o_awready;
  assign w_take = i_wvalid && o_wready;
  assign wr_fire = aw_have_reg && w_have_reg && !o_bvalid;
  assign wr_hit = is_known_addr(aw_addr_reg);
  assign busy_clr = wr_fire && (aw_addr_reg == fsp_pkg::OFS_CTRL) && w_strb_reg[0]
                    && w_data_reg[fsp_pkg::CTRL_BUSY_CLR_BIT];

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      aw_have_reg <= 1'b0;
    end else if (aw_take) begin
      aw_have_reg <= 1'b1;
    end else if (wr_fire) begin
      aw_have_reg <= 1'b0;
    end
  end

  // address kept until the write fires; data may still be on its way
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      aw_addr_reg <= 4'h0;
    end else if (aw_take) begin
      aw_addr_reg <= i_awaddr;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      w_have_reg <= 1'b0;
    end else if (w_take) begin
      w_have_reg <= 1'b1;
    end else if (wr_fire) begin
      w_have_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end else if (w_take) begin
      w_data_reg <= i_wdata;
      w_strb_reg <= i_wstrb;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_bvalid <= 1'b0;
    end else if (wr_fire) begin
      o_bvalid <= 1'b1;
    end else if (i_bready) begin
      o_bvalid <= 1'b0;
    end
  end

  // the code is latched with the write so it stands while bvalid waits
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_bresp <= fsp_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      o_bresp <= wr_hit ? fsp_pkg::RESP_OKAY : fsp_pkg::RESP_SLVERR;
    end
  end

  // axi4-lite read: data and response one cycle after the address is taken
  assign o_arready = !o_rvalid;
  assign ar_take = i_arvalid && o_arready;
  assign status_now = status_word(busy_reg, prog_active, o_cpu_halt, refused_reg);

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_rvalid <= 1'b0;
    end else if (ar_take) begin
      o_rvalid <= 1'b1;
    end else if (i_rready) begin
      o_rvalid <= 1'b0;
    end
  end

  // control reads answer okay with zero data
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_rresp <= fsp_pkg::RESP_OKAY;
    end else if (ar_take) begin
      o_rresp <= is_known_addr(i_araddr) ? fsp_pkg::RESP_OKAY : fsp_pkg::RESP_SLVERR;
    end
  end

  // status is sampled as the address is taken; other reads return zero
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 32'h0000_0000;
    end else if (ar_take) begin
      if (i_araddr == fsp_pkg::OFS_STATUS) begin
        o_rdata <= status_now;
      end else begin
        o_rdata <= 32'h0000_0000;
      end
    end
  end
endmodule // fsp_ctrl
`default_nettype wire

// ### tb/fsp_cpu_model.sv
// fsp_cpu_model: cpu side that issues store-program instructions.
// assumes store_prog is called from just after a rising edge.
`timescale 1ns/1ns
`default_nettype none
module fsp_cpu_model (
  input wire logic i_clk_sys,
  output var fsp_pkg::fsp_req_t o_req
);
  initial o_req = '0;
  // one-cycle pulse; pc is always loader or app code, never the busy area
  task automatic store_prog(input fsp_pkg::fsp_op_t op, input logic [14:0] pc,
                            input logic [14:0] t);
    @(posedge i_clk_sys);
    o_req <= '{1'b1, op, pc, t};
    @(posedge i_clk_sys);
    o_req.valid <= 1'b0;
  endtask
endmodule // fsp_cpu_model
`default_nettype wire

// ### tb/fsp_ctrl_asserts.sv
// fsp_ctrl_asserts: port-level timing checks for fsp_ctrl.
// assumes the bind below; one clock domain.
`timescale 1ns/1ns
`default_nettype none
module fsp_ctrl_asserts (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire fsp_pkg::fsp_req_t i_req,
  input wire logic o_cpu_halt,
  input wire logic o_area_blocked,
  input wire logic o_flash_start,
  input wire logic [14:0] o_flash_addr,
  input wire logic o_bvalid,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic o_rvalid
);
  logic [15:0] hcnt;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      hcnt <= 16'h0;
    end else begin
      hcnt <= o_cpu_halt ? hcnt + 16'h1 : 16'h0;
    end
  end
  sequence s_app_req;
    i_req.valid && i_req.pc < fsp_pkg::LOADER_START_SZ0;
  endsequence
  a_app_refused: assert property (s_app_req |=> !o_flash_start)
    else $error("start after application request");
  a_app_quiet: assert property (i_req.valid && i_req.pc < fsp_pkg::LOADER_START_SZ0
    && !o_area_blocked && !o_cpu_halt |=> !o_area_blocked && !o_cpu_halt)
    else $error("application request had effect");
  a_halt_cause: assert property ($rose(o_cpu_halt) |-> o_flash_start
    && o_flash_addr >= fsp_pkg::STALL_AREA_START) else $error("halt without stall-area start");
  a_busy_cause: assert property ($rose(o_area_blocked) |-> o_flash_start
    && o_flash_addr < fsp_pkg::STALL_AREA_START) else $error("busy without concurrent-area start");
  a_conc_runs: assert property (o_flash_start
    && o_flash_addr < fsp_pkg::STALL_AREA_START |-> !o_cpu_halt)
    else $error("cpu halted for concurrent-area op");
  a_halt_length: assert property ($fell(o_cpu_halt) |-> hcnt == fsp_pkg::PROG_CYCLES_W)
    else $error("halt length wrong");
  a_busy_holds: assert property (o_area_blocked |=> o_area_blocked || o_bvalid)
    else $error("busy dropped without write");
  a_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read not answered");
endmodule // fsp_ctrl_asserts
bind fsp_ctrl fsp_ctrl_asserts u_chk (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_req(i_req),
  .o_cpu_halt(o_cpu_halt), .o_area_blocked(o_area_blocked), .o_flash_start(o_flash_start),
  .o_flash_addr(o_flash_addr), .o_bvalid(o_bvalid), .i_arvalid(i_arvalid),
  .o_arready(o_arready), .o_rvalid(o_rvalid));
`default_nettype wire

// ### tb/flash_self_program_section_control_test.sv
// flash_self_program_section_control_test: directed bench for fsp_ctrl.
// assumes the cpu model drives requests and tasks here drive the register bus.
`timescale 1ns/1ns
`default_nettype none
module flash_self_program_section_control_test;
  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  fsp_pkg::fsp_req_t req;
  fsp_pkg::fsp_fuse_t fuse = '{2'h3, 2'h3, 2'h0};
  fsp_pkg::fsp_op_t fop;
  logic halt, blk, start, awr, wr, bv, arr, rv, rd_mode = 1'b0, av = 1'b0, wv = 1'b0, bw = 1'b0;
  logic [14:0] faddr;
  logic [3:0] ad = 4'h0;
  logic [31:0] wd = 32'h0, rdata, rdat;
  logic [1:0] bresp, rresp, rsp;
  logic bz = 1'b0;
  int error_cnt = 0;
  int cmp_count = 0;
  logic [14:0] lstart [4] = '{fsp_pkg::LOADER_START_SZ0, fsp_pkg::LOADER_START_SZ1,
                              fsp_pkg::LOADER_START_SZ2, fsp_pkg::LOADER_START_SZ3};
  always #5 i_clk_sys = ~i_clk_sys;
  fsp_cpu_model i_cpu (.i_clk_sys(i_clk_sys), .o_req(req));
  fsp_ctrl i_dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_req(req), .i_fuse(fuse),
    .o_cpu_halt(halt), .o_area_blocked(blk), .o_flash_start(start), .o_flash_op(fop),
    .o_flash_addr(faddr), .i_awaddr(ad), .i_awvalid(av & !rd_mode), .o_awready(awr),
    .i_wdata(wd), .i_wstrb(4'hf), .i_wvalid(wv), .o_wready(wr), .o_bresp(bresp), .o_bvalid(bv),
    .i_bready(bw & !rd_mode), .i_araddr(ad), .i_arvalid(av & rd_mode), .o_arready(arr),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rv), .i_rready(bw & rd_mode));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic final_report;
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // valids drop only at an edge where ready was seen high
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    logic ta, tw, dn;
    dn = 1'b0;
    @(posedge i_clk_sys);
    rd_mode <= !w;
    ad <= a;
    wd <= d;
    av <= 1'b1;
    wv <= w;
    bw <= 1'b1;
    for (int n = 0; n < 99 && !dn; n++) begin
      @(negedge i_clk_sys);
      ta = w ? awr : arr;
      tw = wr;
      dn = w ? bv : rv;
      rsp = w ? bresp : rresp;
      rdat = rdata;
      @(posedge i_clk_sys);
      if (ta) av <= 1'b0;
      if (tw) wv <= 1'b0;
      if (dn) bw <= 1'b0;
    end
    if (!dn) begin
      error_cnt++;
      final_report;
    end
  endtask
  task automatic run(input fsp_pkg::fsp_op_t op, input logic [14:0] pc, input logic [14:0] t,
                     input logic ok);
    i_cpu.store_prog(op, pc, t);
    @(negedge i_clk_sys);
    chk("start", ok, start);
    chk("halt", ok && t >= fsp_pkg::STALL_AREA_START, halt);
    if (ok) bz = bz | (t < fsp_pkg::STALL_AREA_START);
    chk("busy", bz, blk);
    if (ok) chk("op", op, fop);
    if (ok) chk("addr", t, faddr);
    if (ok) repeat (fsp_pkg::PROG_CYCLES) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    chk("halt end", 0, halt);
  endtask
  initial begin
    repeat (2) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    acc(0, fsp_pkg::OFS_STATUS, 0);
    chk("status", 32'h0, rdat);
    run(fsp_pkg::FSP_OP_ERASE, 15'h0100, 15'h0200, 0);
    acc(0, fsp_pkg::OFS_STATUS, 0);
    chk("status", 32'h1 << fsp_pkg::ST_REFUSED_BIT, rdat);
    run(fsp_pkg::FSP_OP_WRITE, 15'h7000, 15'h0100, 1);
    acc(1, fsp_pkg::OFS_STATUS, 32'hf);
    chk("bresp", fsp_pkg::RESP_OKAY, rsp);
    acc(0, fsp_pkg::OFS_STATUS, 0);
    chk("status", 32'h1 << fsp_pkg::ST_BUSY_BIT, rdat);
    acc(1, fsp_pkg::OFS_CTRL, 32'h1);
    bz = 1'b0;
    acc(0, 4'h8, 0);
    chk("rresp", fsp_pkg::RESP_SLVERR, rsp);
    chk("rdata", 32'h0, rdat);
    for (int s = 0; s < 4; s++) begin
      @(posedge i_clk_sys);
      fuse.loader_size <= 2'(s);
      run(fsp_pkg::FSP_OP_ERASE, lstart[s] - 15'h1, 15'h7000, 0);
      run(fsp_pkg::FSP_OP_WRITE, lstart[s], 15'h7000 + 15'(s), 1);
    end
    run(fsp_pkg::FSP_OP_ERASE, 15'h7fff, 15'h6fff, 1);
    @(posedge i_clk_sys);
    fuse <= '{2'h3, 2'h2, 2'h3};
    run(fsp_pkg::FSP_OP_WRITE, 15'h7fff, 15'h7f00, 0);
    run(fsp_pkg::FSP_OP_WRITE, 15'h7fff, 15'h0040, 1);
    @(posedge i_clk_sys);
    fuse <= '{2'h2, 2'h3, 2'h3};
    run(fsp_pkg::FSP_OP_ERASE, 15'h7fff, 15'h0040, 0);
    run(fsp_pkg::FSP_OP_ERASE, 15'h7fff, 15'h7f00, 1);
    acc(1, fsp_pkg::OFS_CTRL, 32'h1);
    @(negedge i_clk_sys);
    chk("busy clr", 0, blk);
    final_report;
  end
  initial begin
    #200000;
    error_cnt++;
    final_report;
  end
endmodule // flash_self_program_section_control_test
`default_nettype wire
